// ---- design/ssf_defs.vh ----
// Constants for the servo status flag block: register map, field
// positions, reset values and power-on timing.
// Assumes inclusion by bare name from the design file.
`ifndef SSF_DEFS_VH
`define SSF_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SSF_FLAGS_OFS 8'h00
`define SSF_IRQ_STAT_OFS 8'h04
`define SSF_IRQ_MASK_OFS 8'h08
`define SSF_INPOS_OFS 8'h0C
`define SSF_NEXT_INPOS_OFS 8'h10
`define SSF_GEAR_NUM_OFS 8'h14
`define SSF_GEAR_DEN_OFS 8'h18
`define SSF_ABS_SEL_OFS 8'h1C
`define SSF_DIR_SEL_OFS 8'h20
`define SSF_OP_MODE_OFS 8'h24

// ****************************************************************
// Flag bit positions (flag register and flag outputs)
// ****************************************************************
`define SSF_F_WARN 0
`define SSF_F_BATT 1
`define SSF_F_TRAVEL 2
`define SSF_F_DBI 3
`define SSF_F_HOME 4
`define SSF_F_FAULT 5
`define SSF_F_COMM 6
`define SSF_NFLAGS 7

// ****************************************************************
// Interrupt event bit positions
// ****************************************************************
`define SSF_E_WARN 0
`define SSF_E_BATT 1
`define SSF_E_FAULT 2
`define SSF_E_HOME_SET 3
`define SSF_E_HOME_LOST 4
`define SSF_NEVENTS 5

// ****************************************************************
// Reset values
// ****************************************************************
`define SSF_INPOS_RST 16'h0064
`define SSF_NEXT_INPOS_RST 16'h0064
`define SSF_GEAR_RST 16'h0001
`define SSF_OP_MODE_RST 4'h0

// ****************************************************************
// Power-on timing
// ****************************************************************
`define SSF_CLK_MHZ 50
`define SSF_TICK_US 1000
`define SSF_TICK_CYC (`SSF_TICK_US * `SSF_CLK_MHZ)
`define SSF_PWRON_MIN_S 4
`define SSF_PWRON_MAX_S 5
// Minimum hold of 4 s counted in 1 ms ticks (4000)
`define SSF_PWRON_TICKS 16'h0FA0

`endif

// ---- design/ssf_top.v ----
// Servo status flag logic with an AHB-Lite register slave.
// Assumes inputs are synchronous to hclk and condition inputs are
// levels except home_done and the single-cycle alarm event inputs.
//
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "ssf_defs.vh"

module ssf_top #(
  parameter [31:0] TICK_CYC = `SSF_TICK_CYC,
  parameter [15:0] PWRON_TICKS = `SSF_PWRON_TICKS
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Servo conditions
  input wire warning_active,
  input wire battery_cable_disconnect_warning,
  input wire battery_low_warning,
  input wire alarm_active,
  input wire signed [31:0] droop_pulses,
  input wire [31:0] remaining_distance,
  input wire servo_on,
  input wire dynamic_brake_required,
  input wire home_done,
  input wire home_busy,
  input wire command_error_alarm,
  input wire absolute_position_erased_alarm,
  input wire absolute_counter_warning,
  // Status flags
  output reg warning_flag,
  output reg battery_warning_flag,
  output reg travel_completion_flag,
  output reg dynamic_brake_interlock_flag,
  output reg home_complete_flag,
  output reg malfunction_flag,
  output reg remote_comm_flag,
  // Interrupt
  output reg irq
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  reg wr_ff;
  reg [7:0] addr_ff;
  reg [15:0] inpos_ff;
  reg [15:0] next_inpos_ff;
  reg [15:0] gear_num_ff;
  reg [15:0] gear_den_ff;
  reg abs_sel_ff;
  reg dir_sel_ff;
  reg [3:0] op_mode_ff;
  reg [`SSF_NEVENTS-1:0] stat_ff;
  reg [`SSF_NEVENTS-1:0] mask_ff;
  reg [`SSF_NEVENTS-1:0] nxt_stat;
  reg [31:0] nxt_rdata;
  wire addr_ok;
  wire [`SSF_NFLAGS-1:0] flags;
  wire wr_inpos;
  wire wr_next;
  wire wr_num;
  wire wr_den;
  wire wr_abs;
  wire wr_dir;
  wire wr_mode;

  // Only the address phase that completes on hready is taken
  assign addr_ok = hsel & hready & htrans[1];

  assign flags = {remote_comm_flag, malfunction_flag, home_complete_flag,
                  dynamic_brake_interlock_flag, travel_completion_flag,
                  battery_warning_flag, warning_flag};

  // Address phase capture; zero wait states, always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      addr_ff <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_ff <= addr_ok & hwrite;
      addr_ff <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= (addr_ok & ~hwrite) ? nxt_rdata : 32'h0000_0000;
    end
  end

  // Read mux; unmapped offsets read as zero
  always @* begin
    case (haddr[7:0])
      `SSF_FLAGS_OFS: nxt_rdata = {25'h000_0000, flags};
      `SSF_IRQ_STAT_OFS: nxt_rdata = {27'h000_0000, stat_ff};
      `SSF_IRQ_MASK_OFS: nxt_rdata = {27'h000_0000, mask_ff};
      `SSF_INPOS_OFS: nxt_rdata = {16'h0000, inpos_ff};
      `SSF_NEXT_INPOS_OFS: nxt_rdata = {16'h0000, next_inpos_ff};
      `SSF_GEAR_NUM_OFS: nxt_rdata = {16'h0000, gear_num_ff};
      `SSF_GEAR_DEN_OFS: nxt_rdata = {16'h0000, gear_den_ff};
      `SSF_ABS_SEL_OFS: nxt_rdata = {31'h0000_0000, abs_sel_ff};
      `SSF_DIR_SEL_OFS: nxt_rdata = {31'h0000_0000, dir_sel_ff};
      `SSF_OP_MODE_OFS: nxt_rdata = {28'h000_0000, op_mode_ff};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Write strobes in the data phase
  assign wr_inpos = wr_ff & (addr_ff == `SSF_INPOS_OFS);
  assign wr_next = wr_ff & (addr_ff == `SSF_NEXT_INPOS_OFS);
  assign wr_num = wr_ff & (addr_ff == `SSF_GEAR_NUM_OFS);
  assign wr_den = wr_ff & (addr_ff == `SSF_GEAR_DEN_OFS);
  assign wr_abs = wr_ff & (addr_ff == `SSF_ABS_SEL_OFS);
  assign wr_dir = wr_ff & (addr_ff == `SSF_DIR_SEL_OFS);
  assign wr_mode = wr_ff & (addr_ff == `SSF_OP_MODE_OFS);

  // ****************************************************************
  // Parameter registers and change detection
  // ****************************************************************
  wire gear_changed;
  wire abs_sel_changed;
  wire dir_changed;
  wire mode_changed;

  // Rewriting the same value is not a change, so no clear follows
  assign gear_changed = (wr_num & (hwdata[15:0] != gear_num_ff)) |
                        (wr_den & (hwdata[15:0] != gear_den_ff));
  assign abs_sel_changed = wr_abs & (hwdata[0] != abs_sel_ff);
  assign dir_changed = wr_dir & (hwdata[0] != dir_sel_ff);
  assign mode_changed = wr_mode & (hwdata[3:0] != op_mode_ff);

  // Parameter storage
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inpos_ff <= `SSF_INPOS_RST;
      next_inpos_ff <= `SSF_NEXT_INPOS_RST;
      gear_num_ff <= `SSF_GEAR_RST;
      gear_den_ff <= `SSF_GEAR_RST;
      abs_sel_ff <= 1'b0;
      dir_sel_ff <= 1'b0;
      op_mode_ff <= `SSF_OP_MODE_RST;
    end else begin
      if (wr_inpos) begin
        inpos_ff <= hwdata[15:0];
      end
      if (wr_next) begin
        next_inpos_ff <= hwdata[15:0];
      end
      if (wr_num) begin
        gear_num_ff <= hwdata[15:0];
      end
      if (wr_den) begin
        gear_den_ff <= hwdata[15:0];
      end
      if (wr_abs) begin
        abs_sel_ff <= hwdata[0];
      end
      if (wr_dir) begin
        dir_sel_ff <= hwdata[0];
      end
      if (wr_mode) begin
        op_mode_ff <= hwdata[3:0];
      end
    end
  end

  // ****************************************************************
  // Power-on hold timer
  // ****************************************************************
  reg [31:0] tick_cnt_ff;
  reg [15:0] ms_cnt_ff;
  reg hold_ff;
  wire tick;

  assign tick = (tick_cnt_ff == TICK_CYC - 32'h0000_0001);

  // Hold lasts the minimum 4 s, well short of the 5 s limit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_ff <= 32'h0000_0000;
      ms_cnt_ff <= 16'h0000;
      hold_ff <= 1'b1;
    end else if (hold_ff) begin
      tick_cnt_ff <= tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
      if (tick) begin
        ms_cnt_ff <= ms_cnt_ff + 16'h0001;
      end
      if (tick & (ms_cnt_ff == PWRON_TICKS - 16'h0001)) begin
        hold_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Travel completion qualification
  // ****************************************************************
  wire [31:0] droop_abs;
  wire in_range;
  wire in_next_range;
  wire rem_zero;

  // Magnitude of droop compared against unsigned ranges
  assign droop_abs = droop_pulses[31] ? (~droop_pulses + 32'h0000_0001) : droop_pulses;
  assign in_range = droop_abs <= {16'h0000, inpos_ff};
  assign in_next_range = droop_abs <= {16'h0000, next_inpos_ff};
  assign rem_zero = (remaining_distance == 32'h0000_0000);

  // ****************************************************************
  // Home return completion
  // ****************************************************************
  wire home_clear;
  wire abs_invalid;

  // Absolute-only invalidations; kept clear until the next home return
  assign abs_invalid = abs_sel_ff & (absolute_position_erased_alarm |
                       absolute_counter_warning);
  assign home_clear = command_error_alarm | home_busy | abs_invalid |
                      gear_changed |
                      abs_sel_changed |
                      dir_changed |
                      mode_changed;

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // All flags registered on hclk so the master sees clean levels
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warning_flag <= 1'b1;
      battery_warning_flag <= 1'b1;
      travel_completion_flag <= 1'b0;
      dynamic_brake_interlock_flag <= 1'b0;
      home_complete_flag <= 1'b0;
      malfunction_flag <= 1'b1;
      remote_comm_flag <= 1'b0;
    end else begin
      warning_flag <= warning_active | hold_ff;
      battery_warning_flag <= battery_cable_disconnect_warning |
                              battery_low_warning | hold_ff;
      travel_completion_flag <= rem_zero & (in_range |
                                (~servo_on & in_next_range));
      dynamic_brake_interlock_flag <= ~dynamic_brake_required;
      malfunction_flag <= alarm_active | hold_ff;
      remote_comm_flag <= 1'b1;
      // Clear conditions beat a coincident completion
      if (home_clear) begin
        home_complete_flag <= 1'b0;
      end else if (home_done) begin
        home_complete_flag <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Interrupt status, mask and output
  // ****************************************************************
  wire [`SSF_NEVENTS-1:0] events;
  wire home_set_next;

  assign home_set_next = ~home_clear & home_done;
  assign events = {home_complete_flag & home_clear,
                   ~home_complete_flag & home_set_next,
                   alarm_active & ~malfunction_flag,
                   (battery_cable_disconnect_warning | battery_low_warning) &
                   ~battery_warning_flag,
                   warning_active & ~warning_flag};

  // Write-one-to-clear; a new event in the same cycle wins
  always @* begin
    nxt_stat = stat_ff;
    if (wr_ff & (addr_ff == `SSF_IRQ_STAT_OFS)) begin
      nxt_stat = stat_ff & ~hwdata[`SSF_NEVENTS-1:0];
    end
    nxt_stat = nxt_stat | events;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_ff <= {`SSF_NEVENTS{1'b0}};
      mask_ff <= {`SSF_NEVENTS{1'b0}};
      irq <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      if (wr_ff & (addr_ff == `SSF_IRQ_MASK_OFS)) begin
        mask_ff <= hwdata[`SSF_NEVENTS-1:0];
      end
      irq <= |(stat_ff & mask_ff);
    end
  end

endmodule // ssf_top

`default_nettype wire

// ---- tb/ssf_checker.sv ----
// Checker for the servo status flag block, bound to ssf_top ports.
// Assumes one clock hclk and the asynchronous active-low hresetn.
`timescale 1ns/10ps
`default_nettype none
module ssf_checker #(
  parameter [31:0] TICK_CYC = 32'h0000_0004,
  parameter [15:0] PWRON_TICKS = 16'h0005
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus request
  input wire logic hsel,
  input wire logic [1:0] htrans,
  // Conditions
  input wire logic warning_active,
  input wire logic battery_cable_disconnect_warning,
  input wire logic battery_low_warning,
  input wire logic alarm_active,
  input wire logic [31:0] remaining_distance,
  input wire logic dynamic_brake_required,
  input wire logic home_done,
  input wire logic home_busy,
  input wire logic command_error_alarm,
  input wire logic absolute_position_erased_alarm,
  input wire logic absolute_counter_warning,
  // Flags
  input wire logic warning_flag,
  input wire logic battery_warning_flag,
  input wire logic travel_completion_flag,
  input wire logic dynamic_brake_interlock_flag,
  input wire logic home_complete_flag,
  input wire logic malfunction_flag,
  input wire logic remote_comm_flag
);
  localparam int HOLD = PWRON_TICKS * TICK_CYC;
  logic [31:0] up_ff;
  logic [31:0] nxt_up;
  logic live;
  // Cycles since release; live skips the edge that still saw reset
  assign nxt_up = (up_ff == 32'hFFFF_FFFF) ? up_ff : up_ff + 32'h0000_0001;
  assign live = (up_ff != 32'h0000_0000);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up_ff <= 32'h0000_0000;
    end else begin
      up_ff <= nxt_up;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A pending parameter write could clear home at the same edge
  sequence s_quiet; !(hsel && htrans[1]) [*4]; endsequence
  sequence s_home_ok; home_done && !home_busy && !command_error_alarm
    && !absolute_position_erased_alarm && !absolute_counter_warning; endsequence
  property p_warn; live && warning_active |=> warning_flag; endproperty
  a_warn: assert property (p_warn) else $error("warning flag missing");
  property p_batt; live && (battery_cable_disconnect_warning || battery_low_warning)
    |=> battery_warning_flag; endproperty
  a_batt: assert property (p_batt) else $error("battery flag missing");
  property p_malf; live && alarm_active |=> malfunction_flag; endproperty
  a_malf: assert property (p_malf) else $error("malfunction flag missing");
  property p_dbi; live |=> dynamic_brake_interlock_flag == !$past(dynamic_brake_required);
  endproperty
  a_dbi: assert property (p_dbi) else $error("brake interlock wrong");
  property p_travel; live && remaining_distance != 32'h0000_0000
    |=> !travel_completion_flag; endproperty
  a_travel: assert property (p_travel) else $error("travel done too early");
  property p_home_clr; live && (home_busy || command_error_alarm) |=> !home_complete_flag;
  endproperty
  a_home_clr: assert property (p_home_clr) else $error("home flag not cleared");
  property p_home_set; live ##0 s_quiet ##0 s_home_ok |=> home_complete_flag; endproperty
  a_home_set: assert property (p_home_set) else $error("home flag not set");
  property p_hold; up_ff < HOLD - 1 |-> warning_flag && battery_warning_flag
    && malfunction_flag; endproperty
  a_hold: assert property (p_hold) else $error("flag dropped in hold");
  // Hold must also end: once past it, a quiet input leaves the flag low
  property p_hold_end; up_ff > HOLD && !$past(warning_active) |-> !warning_flag;
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("warning flag held too long");
  property p_comm; live |-> remote_comm_flag; endproperty
  a_comm: assert property (p_comm) else $error("comm flag low");
endmodule // ssf_checker
bind ssf_top ssf_checker #(.TICK_CYC(TICK_CYC), .PWRON_TICKS(PWRON_TICKS)) ssf_checker_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .warning_active(warning_active), .alarm_active(alarm_active),
  .battery_cable_disconnect_warning(battery_cable_disconnect_warning),
  .battery_low_warning(battery_low_warning), .remaining_distance(remaining_distance),
  .dynamic_brake_required(dynamic_brake_required), .home_done(home_done),
  .home_busy(home_busy), .command_error_alarm(command_error_alarm),
  .absolute_position_erased_alarm(absolute_position_erased_alarm),
  .absolute_counter_warning(absolute_counter_warning), .warning_flag(warning_flag),
  .battery_warning_flag(battery_warning_flag), .malfunction_flag(malfunction_flag),
  .travel_completion_flag(travel_completion_flag), .home_complete_flag(home_complete_flag),
  .dynamic_brake_interlock_flag(dynamic_brake_interlock_flag),
  .remote_comm_flag(remote_comm_flag));
`default_nettype wire

// ---- tb/ssf_station_model.sv ----
// Master station model: takes the cyclic status word each cycle.
// Assumes the flag outputs of ssf_top in register bit order.
`timescale 1ns/10ps
`default_nettype none
module ssf_station_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Flags from the device
  input wire logic [6:0] flags,
  // Last word received
  output logic [6:0] word_ff
);
  // One cycle of link latency, as a real refresh would add
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_ff <= 7'h00;
    end else begin
      word_ff <= flags;
    end
  end
endmodule // ssf_station_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for ssf_top, with the station model beside it.
// Assumes a short power-on hold: 5 ticks of 4 cycles.
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {logic [5:0] cn; logic [31:0] rm; logic [31:0] dp; logic [6:0] ex;}
    ssf_row_t;
  // Inputs defined at time zero; cond is warn,cable,low,alarm,brake,servo
  int fail_count = 0;
  int checks_done = 0;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] rem = 32'h0000_0000;
  logic [31:0] droop = 32'h0000_0000;
  logic [5:0] cond = 6'h01;
  logic [3:0] ev = 4'h0;
  logic hd = 1'b0;
  logic [31:0] rdv;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire irq;
  wire [6:0] flags;
  wire [6:0] word_ff;
  ssf_row_t rows [6] = '{'{6'h01, 32'h0000_0000, 32'h0000_0000, 7'h4C},
    '{6'h21, 32'h0000_0005, 32'h0000_0000, 7'h49}, '{6'h11, 32'h0000_0000, 32'h0000_0000, 7'h4E},
    '{6'h0B, 32'h0000_0000, 32'h0000_0064, 7'h46}, '{6'h05, 32'h0000_0000, 32'hFFFF_FF9B, 7'h68},
    '{6'h01, 32'h0000_0000, 32'hFFFF_FF9C, 7'h4C}};
  logic [7:0] ra [8] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28};
  logic [31:0] rv [8] = '{32'h0000_0064, 32'h0000_0064, 32'h0000_0001, 32'h0000_0001,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  logic [7:0] ca [5] = '{8'h14, 8'h18, 8'h20, 8'h24, 8'h1C};
  logic [31:0] cv [5] = '{32'h0000_0002, 32'h0000_0003, 32'h0000_0001, 32'h0000_0001,
    32'h0000_0001};
  ssf_top #(.TICK_CYC(32'h0000_0004), .PWRON_TICKS(16'h0005)) ssf_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .warning_active(cond[5]),
    .battery_cable_disconnect_warning(cond[4]), .battery_low_warning(cond[3]),
    .alarm_active(cond[2]), .droop_pulses(droop), .remaining_distance(rem),
    .servo_on(cond[0]), .dynamic_brake_required(cond[1]), .home_done(hd),
    .home_busy(ev[0]), .command_error_alarm(ev[1]), .absolute_position_erased_alarm(ev[2]),
    .absolute_counter_warning(ev[3]), .warning_flag(flags[0]), .battery_warning_flag(flags[1]),
    .travel_completion_flag(flags[2]), .dynamic_brake_interlock_flag(flags[3]),
    .home_complete_flag(flags[4]), .malfunction_flag(flags[5]), .remote_comm_flag(flags[6]),
    .irq(irq));
  ssf_station_model ssf_station_model_i (.hclk(hclk), .hresetn(hresetn), .flags(flags),
    .word_ff(word_ff));
  // 50 MHz clock
  always #10 hclk = ~hclk;
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Single word transfer; the address phase holds until hready is seen
  task bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task home();
    hd <= 1'b1;
    cyc(1);
    hd <= 1'b0;
    cyc(2);
  endtask
  task end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog: the whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge hclk);
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_of_test();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    cyc(6);
    hresetn <= 1'b1;
    cyc(2);
    chk(flags, 7'h6F);
    bus(8'h00, 1'b0, 32'h0000_0000);
    chk(rdv, 32'h0000_006F);
    for (int i = 0; i < 8; i++) begin
      bus(ra[i], 1'b0, 32'h0000_0000);
      chk(rdv, rv[i]);
    end
    $display("power-on test done");
    cyc(30);
    for (int i = 0; i < 6; i++) begin
      cond <= rows[i].cn;
      rem <= rows[i].rm;
      droop <= rows[i].dp;
      cyc(3);
      chk(word_ff, rows[i].ex);
    end
    $display("row test done");
    // Servo off: the wider next-station range also counts
    bus(8'h0C, 1'b1, 32'h0000_000A);
    bus(8'h10, 1'b1, 32'h0000_00C8);
    cond <= 6'h00;
    droop <= 32'h0000_0096;
    cyc(3);
    chk(flags[2], 1'b1);
    cond <= 6'h01;
    cyc(3);
    chk(flags[2], 1'b0);
    droop <= 32'h0000_0000;
    $display("servo-off test done");
    // Erased alarm in incremental mode leaves home set
    home();
    ev <= 4'h4;
    cyc(1);
    ev <= 4'h0;
    cyc(3);
    chk(flags[4], 1'b1);
    for (int k = 0; k < 9; k++) begin
      home();
      chk(flags[4], 1'b1);
      if (k < 2 || k > 6) ev <= 4'h1 << (k < 2 ? k : k - 5);
      else bus(ca[k - 2], 1'b1, cv[k - 2]);
      cyc(1);
      ev <= 4'h0;
      cyc(3);
      chk(flags[4], 1'b0);
    end
    home();
    bus(8'h20, 1'b1, 32'h0000_0001);
    cyc(3);
    chk(flags[4], 1'b1);
    $display("home test done");
    // Interrupt: bit0 unmasked, bit1 masked
    bus(8'h04, 1'b1, 32'h0000_001F);
    bus(8'h08, 1'b1, 32'h0000_0001);
    cond <= 6'h29;
    cyc(4);
    chk(irq, 1'b1);
    bus(8'h04, 1'b0, 32'h0000_0000);
    chk(rdv, 32'h0000_0003);
    bus(8'h04, 1'b1, 32'h0000_0001);
    cyc(3);
    chk(irq, 1'b0);
    bus(8'h04, 1'b0, 32'h0000_0000);
    chk(rdv, 32'h0000_0002);
    cond <= 6'h01;
    $display("interrupt test done");
    // Reset in mid-run
    hresetn <= 1'b0;
    cyc(2);
    chk({hreadyout, hresp, flags}, 9'h123);
    hresetn <= 1'b1;
    cyc(3);
    chk({flags[6], flags[4]}, 2'h2);
    bus(8'h20, 1'b0, 32'h0000_0000);
    chk(rdv, 32'h0000_0000);
    $display("reset test done");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
